// >>> fecmd_pkg.sv
// shared constants, tables and state types for the serial flash command ends
// assumes: both ends run on one 25 MHz system clock with synchronous reset
`default_nettype none
package fecmd_pkg;
  // ****************
  // command codes
  // ****************
  localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OPC_ERASE_A      = 8'h60;
  localparam logic [7:0] OPC_ERASE_B      = 8'hC7;
  localparam logic [7:0] OPC_MAKER_DEV    = 8'h90;
  localparam logic [7:0] OPC_IDENT        = 8'h9F;
  localparam logic [7:0] OPC_UNIQUE       = 8'h4B;
  localparam logic [7:0] OPC_PARAM        = 8'h5A;
  localparam logic [7:0] OPC_STATUS       = 8'h05;
  // ****************
  // frame geometry
  // ****************
  localparam int OPC_BITS    = 8;
  localparam int ADDR_BITS   = 24;
  localparam int UID_DUMMY   = 4;
  localparam int PARAM_DUMMY = 8;
  localparam int BYTE_LAST   = 7;
  localparam int IDENT_BYTES = 3;
  localparam logic [23:0] SWAP_ADDR = 24'h000001;
  localparam int STAT_WIP_BIT = 0;
  localparam int STAT_WEL_BIT = 1;
  localparam logic [7:0] FILL_BYTE = 8'hFF;
  // ****************
  // parameter tables
  // ****************
  localparam int PARAM_HDR_LEN = 24;
  localparam int PARAM_VID_IDX = 16;
  localparam logic [7:0] PARAM_HDR [PARAM_HDR_LEN] = '{
    8'h53, 8'h46, 8'h44, 8'h50, 8'h02, 8'h01, 8'h01, 8'hFF,
    8'h00, 8'h02, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hFF,
    8'h00, 8'h02, 8'h01, 8'h03, 8'h60, 8'h00, 8'h00, 8'hFF};
  localparam logic [7:0] PARAM_BASIC_BASE = 8'h30;
  localparam int PARAM_BASIC_LEN = 12;
  localparam logic [7:0] PARAM_BASIC [PARAM_BASIC_LEN] = '{
    8'hE5, 8'h20, 8'h91, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'h00,
    8'h00, 8'hFF, 8'h00, 8'hFF};
  // ****************
  // controller registers
  // ****************
  localparam logic [7:0] REG_CMD  = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_RXD  = 8'h0C;
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_AEN_BIT = 8;
  localparam int CMD_DUM_LSB = 12;
  localparam int CMD_RXB_LSB = 16;
  localparam int HALF_MIN    = 6;
  // ****************
  // state types
  // ****************
  typedef enum logic [2:0] {
    DS_IDLE  = 3'b000,
    DS_OPC   = 3'b001,
    DS_HOLD  = 3'b010,
    DS_ADDR  = 3'b011,
    DS_DUMMY = 3'b100,
    DS_OUT   = 3'b101,
    DS_SKIP  = 3'b110
  } fecmd_dstate_t;
  typedef enum logic [2:0] {
    SRC_STAT  = 3'b000,
    SRC_MDID  = 3'b001,
    SRC_IDENT = 3'b010,
    SRC_UID   = 3'b011,
    SRC_PARAM = 3'b100
  } fecmd_src_t;
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_RUN  = 2'b01,
    HS_END  = 2'b10,
    HS_GAP  = 2'b11
  } fecmd_hstate_t;
endpackage : fecmd_pkg
`default_nettype wire

// >>> fecmd_if.sv
// serial link between flash device end and host controller end
// assumes: the bench resolves nothing; every wire has one driver
`timescale 1ns/1ps
`default_nettype none
interface fecmd_if;
  logic sclk;
  logic cs_n;
  logic si;
  logic so;
  modport dev_mp  (input sclk, input cs_n, input si, output so);
  modport host_mp (output sclk, output cs_n, output si, input so);
endinterface : fecmd_if
`default_nettype wire

// >>> fecmd_sync.sv
// two-stage synchroniser for signals from another clock domain
// assumes: inputs are levels that stay put for several clocks
`timescale 1ns/1ps
`default_nettype none
module fecmd_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  // data
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } fecmd_sync_t;
  fecmd_sync_t q, d;
  if (W < 1) begin : g_chk
    $error("fecmd_sync: W must be at least 1");
  end
  always_comb begin
    d    = q;
    d.s1 = d_in;
    d.s2 = q.s1;
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign q_out = q.s2;
endmodule : fecmd_sync
`default_nettype wire

// >>> fecmd_dev.sv
// flash device end: erase, identification and parameter table commands
// assumes: SPI mode 0 or 3 on the link, link pins slower than MCLK_IN / 6
//
// Operation
// [RQ1] erase opcodes need write enable latch set
// [RQ2] erase only if select rises after opcode
// [RQ3] erase starts at select rise, flag busy
// [RQ4] latch cleared before erase finishes
// [RQ5] erase refused when any protect bit set
// [RQ6] address zero: maker then device identity
// [RQ7] address one: device identity first
// [RQ8] identification: maker, type, capacity bytes
// [RQ9] identification: 24 bits on falling edges
// [RQ10] identification read ignored while busy
// [RQ11] select rise ends read, back to standby
// [RQ12] unique number after four dummy clocks
// [RQ13] unique number fixed, never alterable
// [RQ14] parameter table opcode returns table bytes
// [RQ15] bytes 0-3 hold signature, LSB first
// [RQ16] header revision, count, unused bytes FF
// [RQ17] first header: standard table, nine dwords
// [RQ18] second header: vendor table, three dwords
// [RQ19] byte 30 E5, byte 31 erase opcode
// [RQ20] byte 32 91, byte 33 FF
// [RQ21] bytes 34-37 density as highest bit
// [RQ22] quad descriptors zero waits, opcode FF
// [RQ23] table read: address, eight dummies, stream
`timescale 1ns/1ps
`default_nettype none
module fecmd_dev
  import fecmd_pkg::*;
#(
  parameter int           ERASE_CYC = 2000,
  parameter logic [7:0]   MAKER_ID  = 8'hA5,           // arbitrary value
  parameter logic [7:0]   DEVICE_ID = 8'h12,           // arbitrary value
  parameter logic [7:0]   MEM_TYPE  = 8'h40,           // arbitrary value
  parameter logic [7:0]   MEM_CAP   = 8'h13,           // arbitrary value
  parameter logic [127:0] UNIQUE_ID = 128'h0123456789ABCDEF_FEDCBA9876543210 // arbitrary value
) (
  // clock and reset
  input  wire logic       MCLK_IN,
  input  wire logic       RESETN_IN,
  // serial link
  fecmd_if.dev_mp         SPI,
  // protection and status
  input  wire logic [2:0] BP_IN,
  output logic            WIP_OUT,
  output logic            WEL_OUT
);
  localparam int ERW = $clog2(ERASE_CYC + 1);

  if (ERASE_CYC < 2) begin : g_chk
    $error("fecmd_dev: ERASE_CYC must be at least 2");
  end

  // ****************
  // state
  // ****************
  typedef struct packed {
    fecmd_dstate_t  st;
    fecmd_src_t     src;
    logic [7:0]     opc;
    logic [4:0]     cnt;
    logic [23:0]    addr;
    logic [2:0]     bit_i;
    logic           so;
    logic           write_enable_latch;
    logic           write_in_progress;
    logic [ERW-1:0] tmr;
    logic           sclk_p;
    logic           cs_p;
  } fecmd_dev_st_t;

  fecmd_dev_st_t q, d;
  logic [2:0]    pins_s;
  logic          sclk_s;
  logic          cs_s;
  logic          si_s;
  logic          rise;
  logic          fall;
  logic          cs_fall;
  logic [7:0]    nopc;
  logic [23:0]   naddr;
  logic [7:0]    obyte;

  // ****************
  // pin synchroniser
  // ****************
  fecmd_sync #(.W(3)) u_sync (
    .clk_in   (MCLK_IN),
    .rst_n_in (RESETN_IN),
    .d_in     ({SPI.sclk, SPI.cs_n, SPI.si}),
    .q_out    (pins_s)
  );
  assign sclk_s = pins_s[2];
  assign cs_s   = pins_s[1];
  assign si_s   = pins_s[0];

  // ****************
  // output byte lookup
  // ****************
  function automatic logic [7:0] param_byte(input logic [23:0] a);
    logic [7:0] b;
    b = FILL_BYTE;
    if (a < 24'(PARAM_HDR_LEN)) begin
      b = PARAM_HDR[a[4:0]];                           // RQ15 RQ16 RQ17
      if (a == 24'(PARAM_VID_IDX)) begin
        b = MAKER_ID;                                  // RQ18
      end
    end else if (a >= 24'(PARAM_BASIC_BASE) &&
                 a < 24'(PARAM_BASIC_BASE) + 24'(PARAM_BASIC_LEN)) begin
      b = PARAM_BASIC[4'(a - 24'(PARAM_BASIC_BASE))];  // RQ19 RQ20 RQ21 RQ22
    end
    return b;
  endfunction : param_byte

  function automatic logic [7:0] out_byte(input fecmd_src_t s, input logic [23:0] a,
                                          input logic write_in_progress, input logic write_enable_latch);
    logic [7:0] b;
    b = FILL_BYTE;
    case (s)
      SRC_STAT: begin
        b = '0;
        b[STAT_WIP_BIT] = write_in_progress;                         // RQ3
        b[STAT_WEL_BIT] = write_enable_latch;
      end
      SRC_MDID: begin
        b = a[0] ? DEVICE_ID : MAKER_ID;               // RQ6 RQ7
      end
      SRC_IDENT: begin
        if (a == 24'h000000) begin
          b = MAKER_ID;                                // RQ8
        end else if (a == 24'h000001) begin
          b = MEM_TYPE;
        end else if (a < 24'(IDENT_BYTES)) begin
          b = MEM_CAP;
        end
      end
      SRC_UID: begin
        b = UNIQUE_ID[8 * (15 - int'(a[3:0])) +: 8];   // RQ12 RQ13
      end
      SRC_PARAM: begin
        b = param_byte(a);                             // RQ14
      end
      default: begin
        b = FILL_BYTE;
      end
    endcase
    return b;
  endfunction : out_byte

  // ****************
  // next state
  // ****************
  assign rise    = sclk_s & ~q.sclk_p;
  assign fall    = ~sclk_s & q.sclk_p;
  assign cs_fall = ~cs_s & q.cs_p;
  assign nopc    = {q.opc[6:0], si_s};
  assign naddr   = {q.addr[22:0], si_s};
  assign obyte   = out_byte(q.src, q.addr, q.write_in_progress, q.write_enable_latch);

  always_comb begin
    d        = q;
    d.sclk_p = sclk_s;
    d.cs_p   = cs_s;
    // self-timed erase
    if (q.write_in_progress) begin
      d.tmr = q.tmr - ERW'(1);
      if (q.tmr == ERW'(1)) begin
        d.write_in_progress = 1'b0;                                  // RQ3
      end
    end
    if (cs_s) begin
      // deselected: single-byte commands act now
      if (!q.cs_p && q.st == DS_HOLD) begin
        case (q.opc)
          OPC_WRITE_ENABLE: begin
            if (!q.write_in_progress) begin
              d.write_enable_latch = 1'b1;
            end
          end
          OPC_ERASE_A, OPC_ERASE_B: begin
            if (q.write_enable_latch && !q.write_in_progress && BP_IN == 3'h0) begin   // RQ1 RQ5
              d.write_in_progress = 1'b1;                              // RQ3
              d.tmr = ERW'(ERASE_CYC);
              d.write_enable_latch = 1'b0;                              // RQ4
            end
          end
          default: begin
          end
        endcase
      end
      d.st    = DS_IDLE;                               // RQ11
      d.so    = 1'b0;
      d.bit_i = '0;
    end else if (cs_fall) begin
      d.st  = DS_OPC;
      d.cnt = '0;
    end else if (rise) begin
      case (q.st)
        DS_OPC: begin
          d.opc = nopc;
          d.cnt = q.cnt + 5'h01;
          if (q.cnt == 5'(OPC_BITS - 1)) begin
            d.cnt   = '0;
            d.addr  = '0;
            d.bit_i = '0;
            if (q.write_in_progress && nopc != OPC_STATUS) begin
              d.st = DS_SKIP;                          // RQ10
            end else begin
              case (nopc)
                OPC_WRITE_ENABLE, OPC_ERASE_A, OPC_ERASE_B: begin
                  d.st = DS_HOLD;
                end
                OPC_STATUS: begin
                  d.st  = DS_OUT;
                  d.src = SRC_STAT;
                end
                OPC_IDENT: begin
                  d.st  = DS_OUT;                      // RQ9
                  d.src = SRC_IDENT;
                end
                OPC_MAKER_DEV: begin
                  d.st  = DS_ADDR;
                  d.src = SRC_MDID;
                end
                OPC_UNIQUE: begin
                  d.st  = DS_DUMMY;
                  d.src = SRC_UID;
                end
                OPC_PARAM: begin
                  d.st  = DS_ADDR;                     // RQ23
                  d.src = SRC_PARAM;
                end
                default: begin
                  d.st = DS_SKIP;
                end
              endcase
            end
          end
        end
        DS_HOLD: begin
          d.st = DS_SKIP;                              // RQ2
        end
        DS_ADDR: begin
          d.addr = naddr;
          d.cnt  = q.cnt + 5'h01;
          if (q.cnt == 5'(ADDR_BITS - 1)) begin
            d.cnt = '0;
            if (q.src == SRC_PARAM) begin
              d.st = DS_DUMMY;                         // RQ23
            end else begin
              d.st   = DS_OUT;
              d.addr = (naddr == SWAP_ADDR) ? 24'h000001 : 24'h000000;  // RQ7
            end
          end
        end
        DS_DUMMY: begin
          d.cnt = q.cnt + 5'h01;
          if ((q.src == SRC_UID && q.cnt == 5'(UID_DUMMY - 1)) ||
              (q.src == SRC_PARAM && q.cnt == 5'(PARAM_DUMMY - 1))) begin
            d.st = DS_OUT;                             // RQ12 RQ23
          end
        end
        default: begin
        end
      endcase
    end else if (fall && q.st == DS_OUT) begin
      d.so    = obyte[3'(BYTE_LAST) - q.bit_i];        // RQ6 RQ9
      d.bit_i = q.bit_i + 3'h1;
      if (q.bit_i == 3'(BYTE_LAST)) begin
        d.addr = q.addr + 24'h000001;                  // RQ23
      end
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RESETN_IN) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ****************
  // outputs
  // ****************
  assign SPI.so  = q.so;
  assign WIP_OUT = q.write_in_progress;
  assign WEL_OUT = q.write_enable_latch;
endmodule : fecmd_dev
`default_nettype wire

// >>> fecmd_host.sv
// host controller end: runs one serial frame per command register write made while idle
// assumes: APB master on MCLK_IN; device samples link pins on its own clock
`timescale 1ns/1ps
`default_nettype none
module fecmd_host
  import fecmd_pkg::*;
#(
  parameter int HALF = 8
) (
  // clock and reset
  input  wire logic        MCLK_IN,
  input  wire logic        RESETN_IN,
  // apb slave
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  // serial link
  fecmd_if.host_mp         SPI
);
  if (HALF < HALF_MIN || HALF > 255) begin : g_chk
    $error("fecmd_host: HALF out of range");
  end

  // ****************
  // state
  // ****************
  typedef struct packed {
    fecmd_hstate_t st;
    logic          sel;
    logic          sclk;
    logic          si;
    logic [7:0]    div;
    logic [11:0]   k;
    logic [7:0]    op;
    logic          aen;
    logic [3:0]    dum;
    logic [7:0]    rxb;
    logic [23:0]   addr;
    logic [31:0]   rxd;
    logic [31:0]   prd;
  } fecmd_host_st_t;

  fecmd_host_st_t q, d;
  logic           so_s;
  logic [11:0]    tx_bits;
  logic [11:0]    total;
  logic           busy;
  logic           mapped;

  fecmd_sync #(.W(1)) u_sync (
    .clk_in   (MCLK_IN),
    .rst_n_in (RESETN_IN),
    .d_in     (SPI.so),
    .q_out    (so_s)
  );

  // bit sent at position n: opcode, then address, then dummy zeros
  function automatic logic tx_bit(input logic [11:0] n, input logic [7:0] op,
                                  input logic aen, input logic [23:0] a);
    logic [31:0] w;
    w = {op, a};
    if (n < 12'(OPC_BITS) || (aen && n < 12'(OPC_BITS + ADDR_BITS))) begin
      return w[5'(31 - int'(n))];
    end
    return 1'b0;
  endfunction : tx_bit

  assign tx_bits = 12'(OPC_BITS) + (q.aen ? 12'(ADDR_BITS) : 12'h000) + 12'(q.dum);
  assign total   = tx_bits + {1'b0, q.rxb, 3'h0};
  assign busy    = (q.st != HS_IDLE);
  assign mapped  = (PADDR_IN == REG_CMD) || (PADDR_IN == REG_ADDR) ||
                   (PADDR_IN == REG_STAT) || (PADDR_IN == REG_RXD);

  // ****************
  // next state
  // ****************
  always_comb begin
    d = q;
    // register read data captured in the setup cycle
    if (PSEL_IN && !PENABLE_IN) begin
      d.prd = 32'h00000000;
      case (PADDR_IN)
        REG_CMD: begin
          d.prd[CMD_OP_LSB +: 8]  = q.op;
          d.prd[CMD_AEN_BIT]      = q.aen;
          d.prd[CMD_DUM_LSB +: 4] = q.dum;
          d.prd[CMD_RXB_LSB +: 8] = q.rxb;
        end
        REG_ADDR: d.prd[23:0] = q.addr;
        REG_STAT: d.prd[0]    = busy;
        REG_RXD:  d.prd       = q.rxd;
        default:  d.prd       = 32'h00000000;
      endcase
    end
    case (q.st)
      HS_IDLE: begin
        if (PSEL_IN && PENABLE_IN && PWRITE_IN) begin
          if (PADDR_IN == REG_ADDR) begin
            d.addr = PWDATA_IN[23:0];
          end else if (PADDR_IN == REG_CMD) begin
            d.op   = PWDATA_IN[CMD_OP_LSB +: 8];
            d.aen  = PWDATA_IN[CMD_AEN_BIT];
            d.dum  = PWDATA_IN[CMD_DUM_LSB +: 4];
            d.rxb  = PWDATA_IN[CMD_RXB_LSB +: 8];
            d.st   = HS_RUN;
            d.sel  = 1'b1;
            d.div  = '0;
            d.k    = '0;
            d.rxd  = '0;
            d.si   = tx_bit(12'h000, PWDATA_IN[CMD_OP_LSB +: 8], 1'b0, 24'h000000);
          end
        end
      end
      HS_RUN: begin
        d.div = q.div + 8'h01;
        if (q.div == 8'(HALF - 1)) begin
          d.div = '0;
          if (!q.sclk) begin
            d.sclk = 1'b1;
            d.k    = q.k + 12'h001;
            if (q.k >= tx_bits) begin
              d.rxd = {q.rxd[30:0], so_s};
            end
          end else begin
            d.sclk = 1'b0;
            if (q.k == total) begin
              d.st = HS_END;
              d.si = 1'b0;
            end else begin
              d.si = tx_bit(q.k, q.op, q.aen, q.addr);
            end
          end
        end
      end
      HS_END, HS_GAP: begin
        d.div = q.div + 8'h01;
        if (q.div == 8'(HALF - 1)) begin
          d.div = '0;
          d.sel = 1'b0;
          d.st  = (q.st == HS_END) ? HS_GAP : HS_IDLE;
        end
      end
      default: begin
        d.st = HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RESETN_IN) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ****************
  // outputs
  // ****************
  assign PRDATA_OUT  = q.prd;
  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~mapped;
  assign SPI.sclk    = q.sclk;
  assign SPI.cs_n    = ~q.sel;
  assign SPI.si      = q.si;
endmodule : fecmd_host
`default_nettype wire

// >>> fecmd_assertions.sv
// checker for the serial link and the device end's status flags
// assumes: instantiated beside the link interface; one clock domain
`timescale 1ns/1ps
`default_nettype none
module fecmd_assertions #(
  parameter int ERASE_CYC = 2000
) (
  // clock and reset
  input wire logic       MCLK_IN,
  input wire logic       RESETN_IN,
  // serial link
  input wire logic       sclk,
  input wire logic       cs_n,
  input wire logic       si,
  input wire logic       so,
  // device pins
  input wire logic [2:0] BP_IN,
  input wire logic       WIP_OUT,
  input wire logic       WEL_OUT
);
  logic [31:0] busy_cnt_q;
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RESETN_IN);
  // ****************
  // erase length counter
  // ****************
  always_ff @(posedge MCLK_IN) begin
    if (!RESETN_IN || !WIP_OUT) begin
      busy_cnt_q <= 32'h0;
    end else begin
      busy_cnt_q <= busy_cnt_q + 32'h1;
    end
  end
  // ****************
  // assertions
  // ****************
  AST_ERASE_NEEDS_WEL: assert property ($rose(WIP_OUT) |-> $past(WEL_OUT))
    else $error("erase started without write enable latch");
  AST_WEL_AT_DESELECT: assert property ($rose(WEL_OUT) |-> cs_n)
    else $error("latch set while selected");
  AST_ERASE_AT_DESELECT: assert property ($rose(WIP_OUT) |-> cs_n && $past(cs_n, 2))
    else $error("erase started while selected");
  AST_ERASE_LENGTH: assert property ($fell(WIP_OUT) |-> busy_cnt_q + 2 >= ERASE_CYC && busy_cnt_q <= ERASE_CYC + 2)
    else $error("erase busy time wrong");
  AST_BUSY_HOLDS: assert property ($rose(WIP_OUT) |-> WIP_OUT [*8])
    else $error("busy flag dropped early");
  AST_WEL_CLEAR_BY_END: assert property ($fell(WIP_OUT) |-> !WEL_OUT)
    else $error("latch still set at erase end");
  AST_ERASE_UNPROTECTED: assert property ($rose(WIP_OUT) |-> BP_IN == 3'h0)
    else $error("erase started while protected");
  AST_SO_QUIET: assert property (cs_n [*4] |-> !so)
    else $error("output active while deselected");
  AST_SO_ON_FALL: assert property (!cs_n && $changed(so) |-> !sclk)
    else $error("output changed while clock high");
  AST_SI_STEADY: assert property (sclk |-> $stable(si))
    else $error("input data moved while clock high");
  AST_SCLK_IDLE: assert property (cs_n |-> !sclk)
    else $error("clock high while deselected");
  COV_ERASE: cover property ($rose(WIP_OUT));
  COV_LATCH: cover property ($rose(WEL_OUT));
  COV_FRAME: cover property ($fell(cs_n));
endmodule : fecmd_assertions
`default_nettype wire

// >>> flash_erase_id_param_cmds_tb_top.sv
// self-checking bench: host end drives device end over the serial link
// assumes: APB access through the host end's registers, fixed identity params
`timescale 1ns/1ps
`default_nettype none
module flash_erase_id_param_cmds_tb_top;
  import fecmd_pkg::*;
  localparam int             ERASE_N = 1000;
  localparam logic [7:0]     MAKER_V = 8'h5C;  // arbitrary value
  localparam logic [7:0]     DEVID_V = 8'h3A;  // arbitrary value
  localparam logic [7:0]     TYPE_V  = 8'h71;  // arbitrary value
  localparam logic [7:0]     CAP_V   = 8'h26;  // arbitrary value
  localparam logic [127:0]   UID_V   = 128'h00112233445566778899AABBCCDDEEFF; // arbitrary value
  localparam logic [7:0]     TA [10] = '{8'h00, 8'h02, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h30, 8'h34, 8'h38};
  localparam logic [31:0]    TW [10] = '{32'h53464450, 32'h44500201, 32'h020101FF, 32'h00020109, 32'h300000FF,
    {MAKER_V, 24'h020103}, 32'h600000FF, 32'hE52091FF, 32'hFFFF3F00, 32'h00FF00FF};
  logic        mclk = 1'h0, resetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [2:0]  bp = 3'h0;
  logic [31:0] prdata, rxd, rd;
  logic        pready, pslverr, write_in_progress, write_enable_latch, err;
  int          n_fail = 0;
  int          total_checks = 0;
  fecmd_if link_if ();
  always #20 mclk = ~mclk;
  fecmd_host i_fecmd_host (.MCLK_IN(mclk), .RESETN_IN(resetn), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .SPI(link_if));
  fecmd_dev #(.ERASE_CYC(ERASE_N), .MAKER_ID(MAKER_V), .DEVICE_ID(DEVID_V), .MEM_TYPE(TYPE_V), .MEM_CAP(CAP_V),
    .UNIQUE_ID(UID_V)) i_fecmd_dev (.MCLK_IN(mclk), .RESETN_IN(resetn), .SPI(link_if), .BP_IN(bp),
    .WIP_OUT(write_in_progress), .WEL_OUT(write_enable_latch));
  fecmd_assertions #(.ERASE_CYC(ERASE_N)) i_fecmd_assertions (.MCLK_IN(mclk), .RESETN_IN(resetn),
    .sclk(link_if.sclk), .cs_n(link_if.cs_n), .si(link_if.si), .so(link_if.so), .BP_IN(bp), .WIP_OUT(write_in_progress),
    .WEL_OUT(write_enable_latch));
  // ****************
  // report and compare
  // ****************
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report
  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check32
  task automatic check1(input logic got, input logic exp);
    check32({31'h0, got}, {31'h0, exp});
  endtask : check1
  // ****************
  // bus and link tasks
  // ****************
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (n >= 50) begin
      n_fail++;
      final_report;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge mclk);
  endtask : apb
  // one frame: address, command, wait for idle, fetch received bits
  task automatic run_cmd(input logic [7:0] op, input logic aen, input logic [3:0] dum, input logic [7:0] nb,
                         input logic [23:0] a);
    int n;
    apb(1'h1, REG_ADDR, {8'h00, a});
    apb(1'h1, REG_CMD, {8'h00, nb, dum, 3'h0, aen, op});
    n = 0;
    do begin
      apb(1'h0, REG_STAT, 32'h0);
      n++;
    end while (rd[0] !== 1'h0 && n < 2000);
    if (n >= 2000) begin
      n_fail++;
      final_report;
    end
    apb(1'h0, REG_RXD, 32'h0);
    rxd = rd;
  endtask : run_cmd
  // bounded wait for a device flag (0 busy, 1 latch), then compare
  task automatic wait_flag(input logic sel, input logic val, input int max);
    int n;
    n = 0;
    while ((sel ? write_enable_latch : write_in_progress) !== val && n < max) begin
      @(posedge mclk);
      n++;
    end
    check1(sel ? write_enable_latch : write_in_progress, val);
  endtask : wait_flag
  // ****************
  // main sequence
  // ****************
  initial begin
    repeat (16) @(posedge mclk);
    resetn <= 1'h1;
    repeat (4) @(posedge mclk);
    check1(write_in_progress, 1'h0);
    check1(write_enable_latch, 1'h0);
    apb(1'h0, 8'h10, 32'h0);
    check32(rd, 32'h0);
    check1(err, 1'h1);
    run_cmd(OPC_IDENT, 1'h0, 4'h0, 8'h03, 24'h0);
    check32(rxd, {8'h00, MAKER_V, TYPE_V, CAP_V});
    run_cmd(OPC_IDENT, 1'h0, 4'h0, 8'h01, 24'h0);
    check32(rxd, {24'h0, MAKER_V});
    run_cmd(OPC_MAKER_DEV, 1'h1, 4'h0, 8'h02, 24'h0);
    check32(rxd, {16'h0, MAKER_V, DEVID_V});
    run_cmd(OPC_MAKER_DEV, 1'h1, 4'h0, 8'h02, 24'h1);
    check32(rxd, {16'h0, DEVID_V, MAKER_V});
    run_cmd(OPC_UNIQUE, 1'h0, 4'h4, 8'h04, 24'h0);
    check32(rxd, UID_V[127:96]);
    for (int i = 0; i < 2; i++) begin
      run_cmd(OPC_UNIQUE, 1'h0, 4'h4, 8'h10, 24'h0);
      check32(rxd, UID_V[31:0]);
    end
    for (int i = 0; i < 10; i++) begin
      run_cmd(OPC_PARAM, 1'h1, 4'h8, 8'h04, {16'h0, TA[i]});
      check32(rxd, TW[i]);
    end
    run_cmd(OPC_ERASE_B, 1'h0, 4'h0, 8'h00, 24'h0);
    repeat (8) @(posedge mclk);
    check1(write_in_progress, 1'h0);
    run_cmd(OPC_WRITE_ENABLE, 1'h0, 4'h0, 8'h00, 24'h0);
    wait_flag(1'h1, 1'h1, 20);
    bp <= 3'h4;
    run_cmd(OPC_ERASE_B, 1'h0, 4'h0, 8'h00, 24'h0);
    repeat (8) @(posedge mclk);
    check1(write_in_progress, 1'h0);
    bp <= 3'h0;
    run_cmd(OPC_WRITE_ENABLE, 1'h0, 4'h0, 8'h00, 24'h0);
    run_cmd(OPC_ERASE_B, 1'h0, 4'h0, 8'h01, 24'h0);
    repeat (8) @(posedge mclk);
    check1(write_in_progress, 1'h0);
    for (int k = 0; k < 2; k++) begin
      run_cmd(OPC_WRITE_ENABLE, 1'h0, 4'h0, 8'h00, 24'h0);
      wait_flag(1'h1, 1'h1, 20);
      run_cmd(k == 0 ? OPC_ERASE_A : OPC_ERASE_B, 1'h0, 4'h0, 8'h00, 24'h0);
      wait_flag(1'h0, 1'h1, 20);
      check1(write_enable_latch, 1'h0);
      run_cmd(OPC_STATUS, 1'h0, 4'h0, 8'h01, 24'h0);
      check32(rxd, 32'h00000001);
      run_cmd(OPC_IDENT, 1'h0, 4'h0, 8'h03, 24'h0);
      check1(write_in_progress, 1'h1);
      check32(rxd, 32'h00000000);
      wait_flag(1'h0, 1'h0, 1200);
      run_cmd(OPC_STATUS, 1'h0, 4'h0, 8'h01, 24'h0);
      check32(rxd, 32'h00000000);
    end
    final_report;
  end
endmodule : flash_erase_id_param_cmds_tb_top
`default_nettype wire
